// ==== core/ppbb_pkg.sv ====
package ppbb_pkg;
  // register map, byte addresses (pairs at word steps)
  localparam logic [7:0] UPPER_BASE   = 8'h00; // pattern_buffer_upper 0..11
  localparam logic [7:0] LOWER_BASE   = 8'h30; // pattern_buffer_lower 0..11
  localparam logic [7:0] ACT_UPPER    = 8'h60; // active_pattern_upper
  localparam logic [7:0] ACT_LOWER    = 8'h64; // active_pattern_lower
  localparam logic [7:0] ACT_WORD     = 8'h68; // both active bytes at once
  localparam int         NUM_PAIRS    = 12;
  localparam logic [7:0] BUF_RESET    = 8'h00;
  // field positions
  localparam int         SEL_HI       = 7;
  localparam int         SEL_LO       = 4;
  localparam logic [3:0] SEL_MAX      = 4'hb;
  // waveform codes
  localparam logic [1:0] WAVE_LOW     = 2'h0;
  localparam logic [1:0] WAVE_PULSE   = 2'h1;
  localparam logic [1:0] WAVE_INV     = 2'h2;
  localparam logic [1:0] WAVE_HIGH    = 2'h3;
  // pin field positions inside the upper and lower bytes
  localparam int         WAVE_W       = 2;  // width of one pin field
  localparam int         PIN5_LO      = 2;  // upper byte
  localparam int         PIN4_LO      = 0;  // upper byte
  localparam int         PIN3_LO      = 6;  // lower byte
  localparam int         PIN2_LO      = 4;  // lower byte
  localparam int         PIN1_LO      = 2;  // lower byte
  localparam int         PIN0_LO      = 0;  // lower byte
  // byte-address bits that pick a register word
  localparam int         ADDR_HI      = 7;
  localparam int         WORD_LO      = 2;
  localparam int         UPPER_IDX_HI = 5;
  // ahb codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;
endpackage

// ==== core/pulse_pattern_buffer_bank.sv ====
// What this block does
// - twelve buffer pairs, upper and lower bytes
// - write strobe rising edge loads selected pair
// - upper bits 7:4 index next pair
// - 00 low, 01 pulse, 10 inverted, 11 high
// - buffer writes reach pins only after load
// - fields: upper 3:2,1:0; lower four pairs
// - active read-only; upper read latches lower
`timescale 1ns/1ps
`default_nettype none
module pulse_pattern_buffer_bank #(
  parameter int PAIRS = 12
) (
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        write_strobe_i,  // load strobe, same clock
  input  wire logic        timer_pulse_i,   // timer_pulse_source, same clock
  output logic [5:0]       pattern_out_o    // pattern_out5..0
);
  // the address map holds at most twelve pairs, so a larger bank, or an
  // empty one, cannot be served
  if (PAIRS < 1 || PAIRS > ppbb_pkg::NUM_PAIRS)
  begin : g_pairs_bad
    $error("PAIRS out of range");
  end

  logic [7:0] buf_upper_q [PAIRS];     // pattern_buffer_upper bank
  logic [7:0] buf_lower_q [PAIRS];     // pattern_buffer_lower bank
  logic [7:0] active_upper_q;          // active_pattern_upper
  logic [7:0] active_lower_q;          // active_pattern_lower
  logic [7:0] lower_latch_q;           // lower snapshot taken on upper read
  logic       strobe_q;                // previous strobe level
  logic       load;                    // strobe rising edge
  logic [3:0] next_sel;                // next_pair_bank_bit + index bits
  // ahb address and data phase tracking
  logic       dp_wr_q;                 // write data phase under way
  logic [7:0] dp_addr_q;               // byte address held for the data phase
  logic       addr_ok;                 // address phase taken this cycle
  logic [7:0] ap_addr;                 // byte address in the address phase
  logic [3:0] ap_upper_idx;            // address-phase pair index, upper bank
  logic [3:0] ap_lower_idx;            // address-phase pair index, lower bank
  logic [3:0] pair_idx;                // data-phase pair index
  logic       is_upper;                // data phase hits the upper bank
  logic       is_lower;                // data phase hits the lower bank
  // waveform fields of the active pair, one per pin
  logic [1:0] pin5_wave_sel;           // active upper bits 3:2
  logic [1:0] pin4_wave_sel;           // active upper bits 1:0
  logic [1:0] pin3_wave_sel;           // active lower bits 7:6
  logic [1:0] pin2_wave_sel;           // active lower bits 5:4
  logic [1:0] pin1_wave_sel;           // active lower bits 3:2
  logic [1:0] pin0_wave_sel;           // active lower bits 1:0

  // the bank answers every transfer at once
  assign hreadyout_o = 1'b1;                  // zero wait states
  assign hresp_o     = ppbb_pkg::HRESP_OKAY;  // always okay
  assign addr_ok     = hsel_i && hready_i && htrans_i == ppbb_pkg::HTRANS_NONSEQ;
  // only the low byte of the address selects a register; upper bits alias
  assign ap_addr      = 8'(haddr_i);
  assign ap_upper_idx = ap_addr[ppbb_pkg::UPPER_IDX_HI:ppbb_pkg::WORD_LO];
  assign ap_lower_idx = 4'(ap_addr[ppbb_pkg::ADDR_HI:ppbb_pkg::WORD_LO]
                           - ppbb_pkg::LOWER_BASE[ppbb_pkg::ADDR_HI:ppbb_pkg::WORD_LO]);

  // decode of the data-phase address
  always_comb
  begin
    // upper bank first, lower bank next, active registers above
    is_upper = dp_addr_q < ppbb_pkg::LOWER_BASE;
    is_lower = dp_addr_q >= ppbb_pkg::LOWER_BASE && dp_addr_q < ppbb_pkg::ACT_UPPER;
    if (is_upper)
      pair_idx = dp_addr_q[ppbb_pkg::UPPER_IDX_HI:ppbb_pkg::WORD_LO];
    else
      pair_idx = 4'(dp_addr_q[ppbb_pkg::ADDR_HI:ppbb_pkg::WORD_LO]
                    - ppbb_pkg::LOWER_BASE[ppbb_pkg::ADDR_HI:ppbb_pkg::WORD_LO]);
  end

  // address phase capture; the write data phase follows one cycle later
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      dp_wr_q   <= 1'b0;                  // no write pending out of reset
      dp_addr_q <= 8'h00;
    end
    else
    begin
      dp_wr_q   <= addr_ok && hwrite_i;   // reads need no data-phase state
      dp_addr_q <= ap_addr;
    end
  end

  // buffer bank writes; only the buffers, never the pins
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < PAIRS; i++)
      begin
        buf_upper_q[i] <= ppbb_pkg::BUF_RESET;
        buf_lower_q[i] <= ppbb_pkg::BUF_RESET;
      end
    end
    else if (dp_wr_q)
    begin
      // addresses past the last pair are dropped
      if (is_upper && 32'(pair_idx) < PAIRS)
        buf_upper_q[pair_idx] <= hwdata_i[7:0];
      else if (is_lower && 32'(pair_idx) < PAIRS)
        buf_lower_q[pair_idx] <= hwdata_i[7:0];
    end
  end

  // strobe edge detector; the reset value matches the idle low strobe so
  // leaving reset never looks like a rising edge
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      strobe_q <= 1'b0;                   // idle level
    else
      strobe_q <= write_strobe_i;
  end
  // a strobe held high loads only once
  assign load     = write_strobe_i && !strobe_q;
  assign next_sel = active_upper_q[ppbb_pkg::SEL_HI:ppbb_pkg::SEL_LO];

  // active pair load on strobe rising edge
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      active_upper_q <= ppbb_pkg::BUF_RESET;
      active_lower_q <= ppbb_pkg::BUF_RESET;
    end
    else if (load)
    begin
      // both bytes move together at the one load edge; a prohibited code
      // holds the active pair rather than index past the bank
      if (next_sel <= ppbb_pkg::SEL_MAX && 32'(next_sel) < PAIRS)
      begin
        active_upper_q <= buf_upper_q[next_sel];
        active_lower_q <= buf_lower_q[next_sel];
      end
    end
  end

  // read data and lower latch; active regs ignore writes
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      hrdata_o      <= 32'h0;
      lower_latch_q <= 8'h00;
    end
    else if (addr_ok && !hwrite_i)
    begin
      hrdata_o <= 32'h0;                  // unmapped and upper bits read zero
      if (ap_addr < ppbb_pkg::LOWER_BASE && 32'(ap_upper_idx) < PAIRS)
        hrdata_o[7:0] <= buf_upper_q[ap_upper_idx];
      else if (ap_addr >= ppbb_pkg::LOWER_BASE && ap_addr < ppbb_pkg::ACT_UPPER
               && 32'(ap_lower_idx) < PAIRS)
        hrdata_o[7:0] <= buf_lower_q[ap_lower_idx];
      else if (ap_addr == ppbb_pkg::ACT_UPPER)
      begin
        // freeze the lower byte so a later byte read pairs with this one
        hrdata_o[7:0] <= active_upper_q;
        lower_latch_q <= active_lower_q;
      end
      else if (ap_addr == ppbb_pkg::ACT_LOWER)
        hrdata_o[7:0] <= lower_latch_q;
      else if (ap_addr == ppbb_pkg::ACT_WORD)
        hrdata_o[15:0] <= {active_upper_q, active_lower_q};
    end
  end

  // split the active pair into per-pin fields
  assign pin5_wave_sel = active_upper_q[ppbb_pkg::PIN5_LO +: ppbb_pkg::WAVE_W];
  assign pin4_wave_sel = active_upper_q[ppbb_pkg::PIN4_LO +: ppbb_pkg::WAVE_W];
  assign pin3_wave_sel = active_lower_q[ppbb_pkg::PIN3_LO +: ppbb_pkg::WAVE_W];
  assign pin2_wave_sel = active_lower_q[ppbb_pkg::PIN2_LO +: ppbb_pkg::WAVE_W];
  assign pin1_wave_sel = active_lower_q[ppbb_pkg::PIN1_LO +: ppbb_pkg::WAVE_W];
  assign pin0_wave_sel = active_lower_q[ppbb_pkg::PIN0_LO +: ppbb_pkg::WAVE_W];

  // waveform source per code
  // every code is legal, so the case needs no default
  function automatic logic wave(input logic [1:0] code, input logic pulse);
    unique case (code)
      ppbb_pkg::WAVE_LOW:   wave = 1'b0;
      ppbb_pkg::WAVE_PULSE: wave = pulse;
      ppbb_pkg::WAVE_INV:   wave = !pulse;
      ppbb_pkg::WAVE_HIGH:  wave = 1'b1;
    endcase
  endfunction

  // pins follow the active fields continuously
  // registered so the pins never glitch while a field is reloaded; they
  // lag the active registers and the timer pulse by one clock
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      pattern_out_o <= 6'h00;              // all pins low in reset
    else
    begin
      pattern_out_o[5] <= wave(pin5_wave_sel, timer_pulse_i);
      pattern_out_o[4] <= wave(pin4_wave_sel, timer_pulse_i);
      pattern_out_o[3] <= wave(pin3_wave_sel, timer_pulse_i);
      pattern_out_o[2] <= wave(pin2_wave_sel, timer_pulse_i);
      pattern_out_o[1] <= wave(pin1_wave_sel, timer_pulse_i);
      pattern_out_o[0] <= wave(pin0_wave_sel, timer_pulse_i);
    end
  end
endmodule
`default_nettype wire

// ==== test/ppbb_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// port checker for the pattern bank
module ppbb_props (
  input wire logic        mclk_i,
  input wire logic        sys_rst_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic        write_strobe_i,
  input wire logic        timer_pulse_i,
  input wire logic [5:0]  pattern_out_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_ready_high: assert property (hreadyout_o) else $error("wait state");
  a_resp_okay: assert property (!hresp_o) else $error("bad resp");
  a_rdata_narrow: assert property (hrdata_o[31:16] == 16'h0) else $error("wide rdata");
  a_rst_rdata: assert property ($past(sys_rst_i) |-> hrdata_o == 32'h0) else $error("rdata");
  a_rst_pins: assert property ($past(sys_rst_i) |-> pattern_out_o == 6'h0) else $error("pins");
  a_pins_hold: assert property (!$rose(write_strobe_i) ##1
    (!$rose(write_strobe_i) && $stable(timer_pulse_i)) |=> $stable(pattern_out_o))
    else $error("pin moved");
  a_load_late: assert property (!$rose(write_strobe_i) ##1
    ($stable(timer_pulse_i) && !$rose(write_strobe_i)) ##1 $rose(write_strobe_i)
    |-> $stable(pattern_out_o)) else $error("early load");
  a_fall_hold: assert property ($fell(write_strobe_i) ##1 $stable(timer_pulse_i)
    |=> $stable(pattern_out_o)) else $error("late load");
  // main scenarios seen
  c_load: cover property ($rose(write_strobe_i));
  c_pins: cover property ($changed(pattern_out_o));
  c_pulse: cover property ($changed(timer_pulse_i));
endmodule
bind pulse_pattern_buffer_bank ppbb_props i_ppbb_props (.mclk_i, .sys_rst_i, .hrdata_o,
  .hreadyout_o, .hresp_o, .write_strobe_i, .timer_pulse_i, .pattern_out_o);
`default_nettype wire

// ==== test/ppbb_drive_stage.sv ====
`timescale 1ns/1ps
`default_nettype none
// drive stage latching the six gate commands
module ppbb_drive_stage (
  input  wire logic       mclk_i,
  input  wire logic [5:0] pins_i,
  output logic [5:0]      phase_o
);
  // gates follow one cycle later
  always_ff @(posedge mclk_i) phase_o <= pins_i;
endmodule
`default_nettype wire

// ==== test/pulse_pattern_buffer_bank_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %0t: bad value", $time); end end
module pulse_pattern_buffer_bank_tb_top;
  logic        mclk_i = 0, sys_rst_i = 1, hsel = 0, hwrite = 0, strobe = 0, tp = 0;
  logic        hready, hresp;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r, x, seed = 32'h2ac5;
  logic [5:0]  pins, phase; // pins and the drive stage's latched copy
  logic [7:0]  up [12], lo [12];
  logic [15:0] act = 0; // model of the active pair
  int          miscompares = 0, compares = 0, cyc = 0, j;
  pulse_pattern_buffer_bank i_pulse_pattern_buffer_bank (.mclk_i, .sys_rst_i, .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .write_strobe_i(strobe), .timer_pulse_i(tp), .pattern_out_o(pins));
  ppbb_drive_stage i_ppbb_drive_stage (.mclk_i, .pins_i(pins), .phase_o(phase));
  initial forever #10 mclk_i = ~mclk_i;
  // hang guard
  always @(posedge mclk_i) if (++cyc == 9000) begin miscompares++; results(); end
  function logic [31:0] rnd();
    seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5; return seed;
  endfunction
  // low, pulse, inverted pulse, high per pin
  function automatic logic [5:0] pin_exp(input logic [15:0] a, input logic t);
    for (int k = 0; k < 6; k++) pin_exp[k] = (a[2*k+:2] == 2'h3) |
      ((a[2*k+:2] == 2'h1) & t) | ((a[2*k+:2] == 2'h2) & !t);
  endfunction
  // one single ahb transfer, read data left in r
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    do @(posedge mclk_i); while (hready !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge mclk_i); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(0, a, 0); `CHK(r, e)
  endtask
  // random pair with a legal next-pair code
  task put(input int i);
    x = rnd(); up[i] = {4'(x[15:8] % 12), x[3:0]}; lo[i] = x[31:24];
    xfer(1, 8'(4 * i), {24'h0, up[i]}); xfer(1, 8'(48 + 4 * i), {24'h0, lo[i]});
  endtask
  task results();
    if (miscompares == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge mclk_i);
    sys_rst_i <= 0;
    @(posedge mclk_i);
    for (j = 0; j < 24; j++) rd_chk(8'(4 * j), 0);
    for (j = 0; j < 12; j++) put(j);
    for (j = 0; j < 12; j++) rd_chk(8'(4 * j), {24'h0, up[j]});
    for (j = 0; j < 12; j++) rd_chk(8'(48 + 4 * j), {24'h0, lo[j]});
    repeat (40)
    begin
      put(rnd() % 12);
      `CHK(pins, pin_exp(act, tp))
      strobe <= 1; tp <= seed[3];
      act = {up[act[15:12]], lo[act[15:12]]};
      @(posedge mclk_i); strobe <= 0; repeat (2) @(posedge mclk_i);
      @(negedge mclk_i); // pins and drive stage settled after the load
      `CHK(pins, pin_exp(act, tp))
      `CHK(phase, pin_exp(act, tp))
      @(posedge mclk_i);
      rd_chk(8'h60, {24'h0, act[15:8]});
      rd_chk(8'h64, {24'h0, act[7:0]});
      rd_chk(8'h68, {16'h0, act});
    end
    xfer(1, 8'h60, 32'hff); rd_chk(8'h60, {24'h0, act[15:8]});
    rd_chk(8'h70, 0);
    results();
  end
endmodule
`default_nettype wire
